// >>> rtl/cidt_pkg.sv
// package: shared constants, types and opcode encodings for the instruction decode and timing core
package cidt_pkg;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;
  localparam int LIT_W = 11;
  localparam int PHASE_W = 2;
  localparam int CYC_W = 2;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;
  localparam logic [PHASE_W-1:0] PHASE_RD = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_WR = 2'h2;
  localparam logic [CYC_W-1:0] CYC_ONE = 2'h1;
  localparam logic [CYC_W-1:0] CYC_TWO = 2'h2;

  // ----------------------------------------------------------------
  // opcode encodings (upper bits or, for control forms, low byte of the 14-bit word)
  // ----------------------------------------------------------------
  localparam logic [1:0] TOP_BYTE = 2'h0;
  localparam logic [1:0] TOP_BIT = 2'h1;
  localparam logic [1:0] TOP_JUMP = 2'h2;
  localparam logic [1:0] TOP_LIT = 2'h3;
  localparam logic [3:0] BYTE_CTRL = 4'h0;
  localparam logic [3:0] BYTE_DEC_SKIP = 4'hb;
  localparam logic [3:0] BYTE_INC_SKIP = 4'hf;
  localparam logic [3:0] BYTE_ROT_LEFT = 4'hd;
  localparam logic [3:0] LIT_ADD_CARRY = 4'hd;
  localparam logic [3:0] LIT_EXIT_LIT = 4'h4;
  localparam logic [3:0] LIT_PTR_MOVE = 4'hf;
  localparam logic [2:0] LIT_REL_BRANCH = 3'h1;
  localparam logic [3:0] LIT_SHIFT_LO = 4'h5;
  localparam logic [3:0] LIT_SHIFT_HI = 4'h7;
  localparam logic [3:0] LIT_SUB_BORROW = 4'hb;
  localparam logic [1:0] BIT_SKIP_ZERO = 2'h2;
  localparam logic [1:0] BIT_SKIP_ONE = 2'h3;
  localparam logic [7:0] CTRL_RET = 8'h08;
  localparam logic [7:0] CTRL_INT_EXIT = 8'h09;
  localparam logic [7:0] CTRL_CALL_ACC = 8'h0a;
  localparam logic [7:0] CTRL_BRANCH_ACC = 8'h0b;
  localparam logic [4:0] CTRL_PTR_MOVE = 5'h02;
  localparam logic [FADDR_W-1:0] IND_ACC0 = 7'h00;
  localparam logic [FADDR_W-1:0] IND_ACC1 = 7'h01;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLS_BYTE = 2'h0,
    CLS_BIT = 2'h1,
    CLS_LITCTRL = 2'h2
  } cidt_class_t;

  typedef enum logic [2:0] {
    KIND_PLAIN = 3'h0,
    KIND_CALL = 3'h1,
    KIND_RETURN = 3'h2,
    KIND_BRANCH = 3'h3,
    KIND_SKIP = 3'h4
  } cidt_kind_t;

  typedef enum logic [1:0] {
    ALU_OTHER = 2'h0,
    ALU_ADD_CARRY = 2'h1,
    ALU_ROT_LEFT_CARRY = 2'h2
  } cidt_alu_t;

  typedef enum logic [1:0] {
    MODE_PRE_INC = 2'h0,
    MODE_PRE_DEC = 2'h1,
    MODE_POST_INC = 2'h2,
    MODE_POST_DEC = 2'h3
  } cidt_ptr_mode_t;

  // flag update mask bit positions
  localparam int FLG_CARRY = 2;
  localparam int FLG_HALF_CARRY = 1;
  localparam int FLG_ZERO = 0;

  typedef struct packed {
    cidt_class_t cls;
    cidt_kind_t kind;
    cidt_alu_t alu;
    logic [FADDR_W-1:0] file_addr;
    logic file_ref;
    logic dest_file;
    logic [2:0] bit_pos;
    logic [LIT_W-1:0] literal;
    logic indirect;
    logic ptr_num;
    cidt_ptr_mode_t ptr_mode;
    logic [2:0] flag_upd;
  } cidt_dec_t;

endpackage

// >>> rtl/cidt_phase_gen.sv
// four-phase clock-enable sequencer that slices each instruction cycle
`timescale 1ns/1ns
module cidt_phase_gen
  import cidt_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // phase outputs
  output logic [PHASE_W-1:0] phase_o,
  output logic last_o
);

  // ----------------------------------------------------------------
  // phase counter
  // ----------------------------------------------------------------
  logic [PHASE_W-1:0] phase_q;
  logic [PHASE_W-1:0] phase_d;

  // four oscillator cycles make one instruction cycle
  assign phase_d = phase_q + 2'h1;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_q <= '0;
    end else if (ce_i) begin
      phase_q <= phase_d;
    end
  end

  assign phase_o = phase_q;
  assign last_o = (phase_q == PHASE_LAST);

endmodule

// >>> rtl/cidt_decoder.sv
// instruction fetch, decode and cycle timing for the 8-bit core
//
// Behaviour
// - decode the 50-instruction set, each a single 14-bit word with operands
// - classify opcodes as byte-oriented, bit-oriented or literal-and-control
// - instructions take one instruction cycle unless listed as multi-cycle
// - direct and accumulator-target subroutine calls take two cycles
// - subroutine return, literal return and interrupt exit take two cycles
// - jumps, branches, bit-test skips and count-skip-zero take two cycles
// - indirect access adds one cycle when the pointer addresses program memory
// - one instruction cycle is four oscillator cycles
// - every file-register instruction except the bit-test skips does read, modify, then store
// - the addressed register is read even when the result only writes it
// - destination bit zero stores to accumulator, one stores to file register
// - file address field selects register 0x00 to 0x7f of the bank
// - bit field selects one of eight bits of the file register
// - pointer number picks one of two pointer and indirect register pairs
// - two-bit mode picks pre/post increment or decrement of the pointer
// - don't-care bits are ignored, either value accepted
// - add-with-carry is byte form 11 1101, updates carry, half carry, zero
// - rotate-left-through-carry is 00 1101 and changes only carry
`timescale 1ns/1ns
module cidt_decoder
  import cidt_pkg::*;
#(
  parameter int EXTRA_IND_CYC = 1
) (
  // clock, reset and enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // program memory
  input wire logic [INSTR_W-1:0] instr_i,
  output logic fetch_o,
  // pointer status from the data path, one bit per pointer
  input wire logic [1:0] ptr_in_prog_i,
  // decoded instruction
  output cidt_dec_t dec_o,
  output logic dec_valid_o,
  // read-modify-write strobes
  output logic file_rd_o,
  output logic file_wr_o,
  output logic acc_wr_o,
  // timing status
  output logic [PHASE_W-1:0] phase_o,
  output logic [CYC_W-1:0] cycles_o,
  output logic stall_o
);

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  logic [PHASE_W-1:0] phase_w;
  logic last_w;

  cidt_phase_gen u_phase (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .phase_o(phase_w),
    .last_o(last_w)
  );

  // ----------------------------------------------------------------
  // decode function
  // ----------------------------------------------------------------
  function automatic cidt_dec_t decode(input logic [INSTR_W-1:0] w);
    cidt_dec_t r;
    logic [1:0] top;
    logic [3:0] sub;
    r = '0;
    top = w[13:12];
    sub = w[11:8];
    r.file_addr = w[6:0];
    r.bit_pos = w[9:7];
    r.literal = w[10:0];
    r.ptr_num = w[2];
    r.ptr_mode = cidt_ptr_mode_t'(w[1:0]);
    unique case (top)
      TOP_BYTE: begin
        if (sub == BYTE_CTRL && !w[7]) begin
          r.cls = CLS_LITCTRL;
          // call, return and branch forms must match the whole low byte; none of its bits is don't-care
          if (w[7:0] == CTRL_CALL_ACC) begin
            r.kind = KIND_CALL;
          end else if (w[7:0] == CTRL_RET || w[7:0] == CTRL_INT_EXIT) begin
            r.kind = KIND_RETURN;
          end else if (w[7:0] == CTRL_BRANCH_ACC) begin
            r.kind = KIND_BRANCH;
          end else if (w[7:3] == CTRL_PTR_MOVE) begin
            r.indirect = 1'b1;
          end
        end else begin
          r.cls = CLS_BYTE;
          r.file_ref = 1'b1;
          r.dest_file = w[7];
          r.flag_upd[FLG_ZERO] = 1'b1;
          if (sub == BYTE_DEC_SKIP || sub == BYTE_INC_SKIP) begin
            r.kind = KIND_SKIP;
            r.flag_upd = '0;
          end
          if (sub == BYTE_ROT_LEFT) begin
            r.alu = ALU_ROT_LEFT_CARRY;
            r.flag_upd = 3'h0;
            r.flag_upd[FLG_CARRY] = 1'b1;
          end
          // clear-accumulator form leaves its low seven bits free
          if (sub == 4'h1 && !w[7]) begin
            r.file_ref = 1'b0;
            // its low bits are free, so no decoded field may carry them out
            r.file_addr = '0;
            r.literal = '0;
            r.ptr_num = 1'b0;
            r.ptr_mode = MODE_PRE_INC;
          end
        end
      end
      TOP_BIT: begin
        r.cls = CLS_BIT;
        r.file_ref = 1'b1;
        if (w[11:10] == BIT_SKIP_ZERO || w[11:10] == BIT_SKIP_ONE) begin
          r.kind = KIND_SKIP;
        end else begin
          r.dest_file = 1'b1;
        end
      end
      TOP_JUMP: begin
        r.cls = CLS_LITCTRL;
        r.kind = w[11] ? KIND_BRANCH : KIND_CALL;
      end
      default: begin
        if (sub == LIT_ADD_CARRY || sub == LIT_SUB_BORROW
            || (sub >= LIT_SHIFT_LO && sub <= LIT_SHIFT_HI)) begin
          r.cls = CLS_BYTE;
          r.file_ref = 1'b1;
          r.dest_file = w[7];
          r.flag_upd[FLG_ZERO] = 1'b1;
          r.flag_upd[FLG_CARRY] = 1'b1;
          if (sub == LIT_ADD_CARRY) begin
            r.alu = ALU_ADD_CARRY;
            r.flag_upd[FLG_HALF_CARRY] = 1'b1;
          end
        end else begin
          r.cls = CLS_LITCTRL;
          if (sub == LIT_EXIT_LIT) begin
            r.kind = KIND_RETURN;
          end else if (sub[3:1] == LIT_REL_BRANCH) begin
            r.kind = KIND_BRANCH;
          end else if (sub == LIT_PTR_MOVE) begin
            r.indirect = 1'b1;
            r.ptr_num = w[6];
          end
        end
      end
    endcase
    // file operand naming either indirect access register goes via a pointer
    if (r.file_ref && (r.file_addr == IND_ACC0 || r.file_addr == IND_ACC1)) begin
      r.indirect = 1'b1;
      r.ptr_num = r.file_addr[0];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // cycle count
  // ----------------------------------------------------------------
  function automatic logic [CYC_W-1:0] cycle_count(input cidt_dec_t d,
                                                   input logic [1:0] prog);
    logic [CYC_W-1:0] n;
    n = (d.kind == KIND_PLAIN) ? CYC_ONE : CYC_TWO;
    // a pointer into program memory needs a slow program-memory read
    if (d.indirect && prog[d.ptr_num]) begin
      n = n + CYC_W'(EXTRA_IND_CYC);
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_EXEC = 2'h1,
    ST_STALL = 2'h3
  } cidt_state_t;

  cidt_state_t state_q;
  cidt_state_t state_d;
  cidt_dec_t dec_q;
  cidt_dec_t dec_d;
  cidt_dec_t dec_new;
  logic [CYC_W-1:0] left_q;
  logic [CYC_W-1:0] left_d;
  logic [CYC_W-1:0] cyc_new;
  logic [CYC_W-1:0] cycles_q;
  logic [CYC_W-1:0] cycles_d;
  logic first_q;
  logic first_d;
  logic take_w;
  logic adv_w;

  assign dec_new = decode(instr_i);
  assign cyc_new = cycle_count(dec_new, ptr_in_prog_i);
  assign adv_w = ce_i && last_w;
  // a new word is taken only when the previous instruction's cycles are spent
  assign take_w = adv_w && (left_q <= CYC_ONE);

  always_comb begin
    state_d = state_q;
    left_d = left_q;
    dec_d = dec_q;
    cycles_d = cycles_q;
    first_d = first_q;
    if (adv_w) begin
      first_d = 1'b0;
      unique case (state_q)
        ST_FETCH, ST_EXEC, ST_STALL: begin
          if (take_w) begin
            dec_d = dec_new;
            left_d = cyc_new;
            cycles_d = cyc_new;
            first_d = 1'b1;
            state_d = ST_EXEC;
          end else begin
            left_d = left_q - CYC_ONE;
            state_d = ST_STALL;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read-modify-write strobes
  // ----------------------------------------------------------------
  logic rd_d;
  logic wr_d;
  logic acc_d;
  logic fetch_d;
  logic valid_d;
  logic stall_d;
  logic dec_live;

  assign dec_live = ce_i && first_q && (state_q == ST_EXEC);
  // read in the first quarter even for store-only forms
  assign rd_d = dec_live && (phase_w == PHASE_RD) && dec_q.file_ref;
  assign wr_d = dec_live && (phase_w == PHASE_WR) && dec_q.file_ref
                && dec_q.dest_file;
  // clear-accumulator and count-skip forms with d low also land in the accumulator
  assign acc_d = dec_live && (phase_w == PHASE_WR) && !dec_q.dest_file
                 && dec_q.cls == CLS_BYTE;
  assign fetch_d = take_w;
  assign valid_d = (state_d == ST_EXEC);
  assign stall_d = (state_d == ST_STALL);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_FETCH;
      left_q <= '0;
      dec_q <= '0;
      cycles_q <= '0;
      first_q <= 1'b0;
    end else begin
      state_q <= state_d;
      left_q <= left_d;
      dec_q <= dec_d;
      cycles_q <= cycles_d;
      first_q <= first_d;
    end
  end

  logic file_rd_q;
  logic file_wr_q;
  logic acc_wr_q;
  logic fetch_q;
  logic valid_q;
  logic stall_q;
  logic [PHASE_W-1:0] phase_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      file_rd_q <= 1'b0;
      file_wr_q <= 1'b0;
      acc_wr_q <= 1'b0;
      fetch_q <= 1'b0;
      valid_q <= 1'b0;
      stall_q <= 1'b0;
      phase_q <= '0;
    end else if (ce_i) begin
      file_rd_q <= rd_d;
      file_wr_q <= wr_d;
      acc_wr_q <= acc_d;
      fetch_q <= fetch_d;
      valid_q <= valid_d;
      stall_q <= stall_d;
      phase_q <= phase_w;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dec_o = dec_q;
  assign cycles_o = cycles_q;
  assign file_rd_o = file_rd_q;
  assign file_wr_o = file_wr_q;
  assign acc_wr_o = acc_wr_q;
  assign fetch_o = fetch_q;
  assign dec_valid_o = valid_q;
  assign stall_o = stall_q;
  assign phase_o = phase_q;

endmodule

// >>> tb/cidt_prog_mem.sv
// program memory model that feeds one instruction word per fetch
`timescale 1ns/1ns
module cidt_prog_mem
  import cidt_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // fetch side
  input wire logic ce_i,
  input wire logic fetch_i,
  output logic [INSTR_W-1:0] instr_o
);
  logic [INSTR_W-1:0] mem [0:15];
  logic [3:0] addr_q;
  // a word stays put until its fetch is acknowledged, as a real array would
  assign instr_o = mem[addr_q];
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_q <= 4'h0;
    end else if (ce_i && fetch_i) begin
      addr_q <= addr_q + 4'h1;
    end
  end
endmodule

// >>> tb/cidt_decoder_props.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ns
module cidt_decoder_chk
  import cidt_pkg::*;
#(
  parameter int EXTRA_IND_CYC = 1
) (
  // clock, reset and inputs
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic [1:0] ptr_in_prog_i,
  // outputs watched
  input wire logic fetch_o,
  input wire cidt_dec_t dec_o,
  input wire logic dec_valid_o,
  input wire logic file_rd_o,
  input wire logic file_wr_o,
  input wire logic acc_wr_o,
  input wire logic [PHASE_W-1:0] phase_o,
  input wire logic [CYC_W-1:0] cycles_o,
  input wire logic stall_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  phase_step_a: assert property (ce_i ##1 ce_i |=> phase_o == $past(phase_o) + 2'h1)
    else $error("phase did not advance");
  freeze_hold_a: assert property (!ce_i |=> $stable(phase_o) && $stable(dec_o))
    else $error("state moved with enable low");
  fetch_gap_a: assert property (fetch_o && ce_i |=> !fetch_o [*3])
    else $error("fetches closer than four");
  read_first_a: assert property (fetch_o && ce_i && dec_o.file_ref |=> file_rd_o)
    else $error("file read missing");
  store_after_read_a: assert property ($rose(file_wr_o) && $past(ce_i) && $past(ce_i, 2)
    |-> $past(file_rd_o, 2))
    else $error("store without earlier read");
  field_take_a: assert property (fetch_o && dec_o.cls == CLS_BYTE && dec_o.file_ref
    |-> dec_o.file_addr == $past(instr_i[6:0]) && dec_o.dest_file == $past(instr_i[7]))
    else $error("file fields wrong");
  bit_field_a: assert property (fetch_o && dec_o.cls == CLS_BIT
    |-> dec_o.bit_pos == $past(instr_i[9:7]))
    else $error("bit position wrong");
  two_cycle_a: assert property (fetch_o && dec_o.kind != KIND_PLAIN && !dec_o.indirect
    |-> cycles_o == CYC_TWO)
    else $error("flow change not two cycles");
  plain_one_a: assert property (fetch_o && dec_o.kind == KIND_PLAIN && !dec_o.indirect
    |-> cycles_o == CYC_ONE)
    else $error("plain op not one cycle");
  ind_extra_a: assert property (fetch_o && dec_o.kind == KIND_PLAIN && dec_o.indirect
    |-> cycles_o == ((($past(ptr_in_prog_i) >> dec_o.ptr_num) & 2'h1) != 2'h0
    ? 2'(1 + EXTRA_IND_CYC) : CYC_ONE))
    else $error("indirect cycle count wrong");
  stall_len_a: assert property ($rose(stall_o) |-> stall_o [*4])
    else $error("stall shorter than four");
  valid_fetch_a: assert property (fetch_o |-> dec_valid_o && !stall_o)
    else $error("fetch outside execute");
  dest_excl_a: assert property (!(acc_wr_o && file_wr_o))
    else $error("result stored twice");
  cover property ($rose(stall_o));
  cover property (fetch_o && cycles_o == CYC_TWO);
  cover property (fetch_o && dec_o.indirect);
  cover property (!ce_i ##1 ce_i);
endmodule

bind cidt_decoder cidt_decoder_chk #(.EXTRA_IND_CYC(EXTRA_IND_CYC)) i_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .instr_i(instr_i),
  .ptr_in_prog_i(ptr_in_prog_i), .fetch_o(fetch_o), .dec_o(dec_o),
  .dec_valid_o(dec_valid_o), .file_rd_o(file_rd_o), .file_wr_o(file_wr_o),
  .acc_wr_o(acc_wr_o), .phase_o(phase_o), .cycles_o(cycles_o), .stall_o(stall_o));

// >>> tb/tb_top.sv
// self-checking bench for the instruction decode and timing core
`timescale 1ns/1ns
module tb_top import cidt_pkg::*;;
  typedef struct packed {
    logic [INSTR_W-1:0] w;
    logic [CYC_W-1:0] cyc;
    cidt_class_t cls;
    cidt_kind_t kind;
    logic [2:0] rwa;
  } cidt_step_t;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic [1:0] ptr_in_prog_i = 2'h0;
  logic [INSTR_W-1:0] instr_i;
  logic fetch_o, dec_valid_o, file_rd_o, file_wr_o, acc_wr_o, stall_o;
  cidt_dec_t dec_o;
  logic [PHASE_W-1:0] phase_o;
  logic [CYC_W-1:0] cycles_o;
  int failures = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  cidt_step_t stp [0:15];
  cidt_dec_t seen [0:15];

  cidt_decoder #(.EXTRA_IND_CYC(1)) i_cidt_decoder (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .ce_i(ce_i), .instr_i(instr_i), .fetch_o(fetch_o),
    .ptr_in_prog_i(ptr_in_prog_i), .dec_o(dec_o), .dec_valid_o(dec_valid_o),
    .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .acc_wr_o(acc_wr_o),
    .phase_o(phase_o), .cycles_o(cycles_o), .stall_o(stall_o));
  cidt_prog_mem i_cidt_prog_mem (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .fetch_i(fetch_o), .instr_o(instr_i));

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // whole run is a few hundred cycles, so this only trips on a hang
  always @(posedge core_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  // ----
  // shared tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic cidt_step_t st(input logic [13:0] w, input logic [1:0] c,
      input cidt_class_t cl, input cidt_kind_t k, input logic [2:0] rwa);
    return '{w, c, cl, k, rwa};
  endfunction

  task automatic wait_fetch(output int ns);
    int t;
    t = 0;
    ns = 0;
    @(negedge core_clk_i);
    while (fetch_o !== 1'b1 && t < 60) begin
      ns += (stall_o === 1'b1) ? 1 : 0;
      @(negedge core_clk_i);
      t++;
    end
    chk("fetch", 16'h1, 16'(fetch_o));
    chk("valid", 16'h1, 16'(dec_valid_o));
  endtask

  // strobe pattern 3'h7 means the strobes of that step are not judged
  task automatic run(input int n, input logic [1:0] prog, input int hold);
    int last;
    int gap;
    int stl;
    int ns;
    logic [2:0] s;
    @(negedge core_clk_i);
    rstn_i = 1'b0;
    ptr_in_prog_i = prog;
    for (int i = 0; i < 16; i++) begin
      i_cidt_prog_mem.mem[i] = (i < n) ? stp[i].w : 14'h0000;
    end
    repeat (10) @(negedge core_clk_i);
    rstn_i = 1'b1;
    for (int i = 0; i <= n; i++) begin
      wait_fetch(ns);
      if (i > 0) begin
        chk("spacing", 16'(gap), 16'(cyc_cnt - last));
        chk("stall", 16'(stl), 16'(ns));
      end
      if (i == n) begin
        break;
      end
      last = cyc_cnt;
      gap = 4 * stp[i].cyc + ((i == 0) ? hold : 0);
      stl = 4 * stp[i].cyc - 4;
      seen[i] = dec_o;
      chk("cycles", 16'(stp[i].cyc), 16'(cycles_o));
      chk("class", 16'(stp[i].cls), 16'(dec_o.cls));
      chk("kind", 16'(stp[i].kind), 16'(dec_o.kind));
      s = 3'h0;
      repeat (3) begin
        @(negedge core_clk_i);
        s = s | {file_rd_o, file_wr_o, acc_wr_o};
      end
      if (stp[i].rwa != 3'h7) begin
        chk("strobes", 16'(stp[i].rwa), 16'(s));
      end
      if (i == 0 && hold > 0) begin
        ce_i = 1'b0;
        repeat (hold) @(negedge core_clk_i);
        ce_i = 1'b1;
      end
    end
  endtask

  // ----
  // scenarios
  // ----
  task automatic sc_single();
    stp[0] = st(14'h07ff, CYC_ONE, CLS_BYTE, KIND_PLAIN, 3'h6);
    stp[1] = st(14'h0720, CYC_ONE, CLS_BYTE, KIND_PLAIN, 3'h5);
    stp[2] = st(14'h00b5, CYC_ONE, CLS_BYTE, KIND_PLAIN, 3'h6);
    run(3, 2'h0, 0);
    chk("addr", 16'h7f, 16'(seen[0].file_addr));
    chk("dest", 16'h0, 16'(seen[1].dest_file));
  endtask

  task automatic sc_calls();
    logic [13:0] w [5] = '{14'h2123, 14'h000a, 14'h0008, 14'h3455, 14'h0009};
    for (int i = 0; i < 5; i++) begin
      stp[i] = st(w[i], CYC_TWO, CLS_LITCTRL, (i < 2) ? KIND_CALL : KIND_RETURN, 3'h0);
    end
    run(5, 2'h0, 0);
    chk("literal", 16'h55, 16'(seen[3].literal[7:0]));
  endtask

  task automatic sc_branch();
    logic [13:0] w [7] = '{14'h2fff, 14'h33ff, 14'h000b, 14'h1f90, 14'h187f, 14'h0ba2,
      14'h0f22};
    for (int i = 0; i < 7; i++) begin
      stp[i] = st(w[i], CYC_TWO, (i < 3) ? CLS_LITCTRL : (i < 5) ? CLS_BIT : CLS_BYTE,
        (i < 3) ? KIND_BRANCH : KIND_SKIP, (i < 3) ? 3'h0 : 3'h4);
    end
    // count-skip forms still store their result where d points
    stp[5].rwa = 3'h6;
    stp[6].rwa = 3'h5;
    run(7, 2'h0, 0);
    chk("bit", 16'h7, 16'(seen[3].bit_pos));
    chk("bit", 16'h0, 16'(seen[4].bit_pos));
  endtask

  task automatic sc_indirect();
    stp[0] = st(14'h0780, CYC_TWO, CLS_BYTE, KIND_PLAIN, 3'h6);
    stp[1] = st(14'h0781, CYC_ONE, CLS_BYTE, KIND_PLAIN, 3'h6);
    stp[2] = st(14'h0010, CYC_TWO, CLS_LITCTRL, KIND_PLAIN, 3'h0);
    for (int m = 0; m < 4; m++) begin
      stp[3 + m] = st(14'h0014 | 14'(m), CYC_ONE, CLS_LITCTRL, KIND_PLAIN, 3'h0);
    end
    stp[7] = st(14'h3f40, CYC_ONE, CLS_LITCTRL, KIND_PLAIN, 3'h0);
    run(8, 2'h1, 0);
    chk("indirect", 16'h1, 16'(seen[7].indirect));
    chk("ptr", 16'h1, 16'(seen[7].ptr_num));
    chk("indirect", 16'h1, 16'(seen[0].indirect));
    chk("ptr", 16'h0, 16'(seen[2].ptr_num));
    for (int m = 0; m < 4; m++) begin
      chk("ptr", 16'h1, 16'(seen[3 + m].ptr_num));
      chk("mode", 16'(m), 16'(seen[3 + m].ptr_mode));
    end
  endtask

  task automatic sc_bits();
    stp[0] = st(14'h16b3, CYC_ONE, CLS_BIT, KIND_PLAIN, 3'h6);
    stp[1] = st(14'h1140, CYC_ONE, CLS_BIT, KIND_PLAIN, 3'h6);
    stp[2] = st(14'h3d21, CYC_ONE, CLS_BYTE, KIND_PLAIN, 3'h5);
    stp[3] = st(14'h0da1, CYC_ONE, CLS_BYTE, KIND_PLAIN, 3'h6);
    stp[4] = st(14'h0103, CYC_ONE, CLS_BYTE, KIND_PLAIN, 3'h1);
    stp[5] = st(14'h0100, CYC_ONE, CLS_BYTE, KIND_PLAIN, 3'h1);
    // enable held low five cycles after the first word stretches its slot
    run(6, 2'h0, 5);
    chk("bit", 16'h5, 16'(seen[0].bit_pos));
    chk("bit", 16'h2, 16'(seen[1].bit_pos));
    chk("alu", 16'(ALU_ADD_CARRY), 16'(seen[2].alu));
    chk("flags", 16'h7, 16'(seen[2].flag_upd));
    chk("alu", 16'(ALU_ROT_LEFT_CARRY), 16'(seen[3].alu));
    chk("flags", 16'h4, 16'(seen[3].flag_upd));
    chk("dontcare", 16'h0, 16'(seen[4] !== seen[5]));
  endtask

  initial begin
    sc_single();
    sc_calls();
    sc_branch();
    sc_indirect();
    sc_bits();
    report_and_stop();
  end
endmodule
